// [hw/trace_pkg.sv]
// Constants and carriers for the trace word counter and comparator C page extension.
// Assumes one 10 MHz clock and an 8-bit register port with read data one cycle later.
package trace_pkg;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFFSET   = 8'h20;
    localparam logic [7:0] COUNT_OFFSET  = 8'h24;
    localparam logic [7:0] CCX_OFFSET    = 8'h25;
    localparam logic [7:0] STATUS_OFFSET = 8'h2a;
    localparam logic [7:0] MASK_OFFSET   = 8'h2b;

    // Control register fields
    localparam int ARM_BIT   = 7;
    localparam int BEGIN_BIT = 4;
    localparam int BRK_BIT   = 3;

    // Count register fields
    localparam int FULL_BIT  = 7;
    localparam int COUNT_MSB = 5;

    // Extension register fields
    localparam int SEL_MSB   = 7;
    localparam int SEL_LSB   = 6;
    localparam int EXT_MSB   = 5;

    // Interrupt status bits
    localparam int EV_FULL   = 0;
    localparam int EV_BREAK  = 1;

    localparam logic [5:0] COUNT_MAX    = 6'h3f;
    localparam logic [6:0] BUFFER_WORDS = 7'h40;

    // Data and extra paging are absent, so the upper select bit is dropped
    localparam logic RESERVED_PAGES_EN = 1'b0;

    // Reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CCX_RESET  = 8'h00;
    localparam logic [1:0] IRQ_RESET  = 2'h0;

    typedef enum logic [1:0] {
        PAGE_NONE,
        PAGE_PROGRAM,
        PAGE_DATA,
        PAGE_EXTRA
    } page_type_t;

    typedef struct packed {
        logic       arm;
        logic       beginMode;
        logic       breakEnable;
    } ctrl_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;

    typedef struct packed {
        logic       wordStrobe;
        logic       trigger;
        logic [5:0] highAddr;
    } core_in_t;

endpackage

// [hw/trace_count_and_page_compare.sv]
// Trace buffer word counter with full flag, plus comparator C page-extended compare.
// Assumes core strobes are synchronous to clk and the register master never stalls.
//
// Notes on behaviour
// - The full flag sets once 64 or more words are captured since the last arming.
// - While full, all 64 buffer entries count as valid whatever the count field holds.
// - Writing a one to the arm bit clears the full flag in count bit 7.
// - While the full flag is clear, count bits 5:0 report the number of valid words, 0 to 63.
// - On wrap to zero the full flag sets and, storing up to the trigger, counting continues.
// - Writing a one to the arm bit clears the whole count register.
// - Storing after the trigger, the arm bit clears when full sets with count zero.
// - At the first fill to 64 words a break request issues only if break enable is set.
// - Full with nonzero count means 64 valid words with the oldest overwritten.
// - Extension bits 7:6 choose the paging type in breakpoint and debug modes.
// - The upper page select bit is ignored, so 10 and 11 act as 00 and 01.
// - Select 00 does no extended compare; 01 matches six bits to address 21:16.
// - Reserved data paging matches bits 3:0 to 19:16, extra paging bits 1:0 to 17:16.
// - Comparator C extension works in breakpoint mode, driven by page select.
// - The begin bit selects storing after the trigger when set, up to it when clear.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/100ps

module trace_count_and_page_compare (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Register port
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWdata,
    input  wire logic       regWr,
    input  wire logic       regRd,
    output logic      [7:0] regRdata,
    // Core side
    input  wire logic       wordStrobe,
    input  wire logic       trigger,
    input  wire logic [5:0] expandedAddressBus,
    output logic            captureEnable,
    output logic      [6:0] validWords,
    output logic            breakRequest,
    output logic            extendedMatch,
    output logic            irq
);

    ////////////////////////////////////////////////////////////////////////

    typedef struct packed {
        trace_pkg::ctrl_t ctrl;
        logic [5:0]       count;
        logic             full;
        logic             trigSeen;
        logic [7:0]       ccx;
        logic [1:0]       status;
        logic [1:0]       mask;
        logic [7:0]       rdata;
        logic             capEn;
        logic [6:0]       valid;
        logic             brk;
        logic             extMatch;
        logic             irq;
    } state_t;

    localparam state_t STATE_RESET = '{
        ctrl:     trace_pkg::ctrl_t'(3'h0),
        count:    6'h00,
        full:     1'b0,
        trigSeen: 1'b0,
        ccx:      trace_pkg::CCX_RESET,
        status:   trace_pkg::IRQ_RESET,
        mask:     trace_pkg::IRQ_RESET,
        rdata:    8'h00,
        capEn:    1'b0,
        valid:    7'h00,
        brk:      1'b0,
        extMatch: 1'b0,
        irq:      1'b0
    };

    trace_pkg::reg_req_t req;
    trace_pkg::core_in_t core;
    state_t              st_reg;
    state_t              st_next;

    assign req  = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};
    assign core = '{wordStrobe: wordStrobe, trigger: trigger, highAddr: expandedAddressBus};

    ////////////////////////////////////////////////////////////////////////

    logic                   storing;
    logic                   storeWord;
    logic                   wrap;
    logic                   armWrite;
    logic                   fullEvent;
    logic                   breakEvent;
    logic [5:0]             countInc;
    logic [1:0]             events;
    trace_pkg::page_type_t  pageType;
    logic [5:0]             cmpMask;
    logic [7:0]             countView;

    assign storing   = st_reg.ctrl.arm && (!st_reg.ctrl.beginMode || st_reg.trigSeen);
    assign storeWord = storing && core.wordStrobe;
    assign countInc  = st_reg.count + 6'h01;
    assign wrap      = storeWord && (st_reg.count == trace_pkg::COUNT_MAX);
    assign armWrite  = req.wr && (req.addr == trace_pkg::CTRL_OFFSET) && req.wdata[trace_pkg::ARM_BIT];
    assign fullEvent  = wrap && !st_reg.full && !armWrite;
    assign breakEvent = fullEvent && st_reg.ctrl.breakEnable;
    assign events     = {breakEvent, fullEvent};
    assign countView  = {st_reg.full, 1'b0, st_reg.count};

    // page type from the select field
    // upper select bit dropped when reserved paging is absent
    always_comb begin
        logic [1:0] sel;
        sel = st_reg.ccx[trace_pkg::SEL_MSB:trace_pkg::SEL_LSB];
        if (!trace_pkg::RESERVED_PAGES_EN) begin
            sel[1] = 1'b0;
        end
        pageType = trace_pkg::page_type_t'(sel);
    end

    // program paging compares all six bits
    // reserved paging compares four or two bits
    always_comb begin
        unique case (pageType)
            trace_pkg::PAGE_NONE:    cmpMask = 6'h00;
            trace_pkg::PAGE_PROGRAM: cmpMask = 6'h3f;
            trace_pkg::PAGE_DATA:    cmpMask = 6'h0f;
            trace_pkg::PAGE_EXTRA:   cmpMask = 6'h03;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////

    always_comb begin
        st_next     = st_reg;
        st_next.brk = 1'b0;

        // Control register write
        if (req.wr && req.addr == trace_pkg::CTRL_OFFSET) begin
            st_next.ctrl.arm         = req.wdata[trace_pkg::ARM_BIT];
            st_next.ctrl.beginMode   = req.wdata[trace_pkg::BEGIN_BIT];
            st_next.ctrl.breakEnable = req.wdata[trace_pkg::BRK_BIT];
        end
        if (req.wr && req.addr == trace_pkg::CCX_OFFSET) begin
            st_next.ccx = req.wdata;
        end
        if (req.wr && req.addr == trace_pkg::MASK_OFFSET) begin
            st_next.mask = req.wdata[1:0];
        end

        if (armWrite) begin
            st_next.count    = 6'h00;
            st_next.full     = 1'b0;
            st_next.trigSeen = 1'b0;
        end else if (st_reg.ctrl.arm) begin
            if (core.trigger) begin
                st_next.trigSeen = 1'b1;
                // end-trigger storing stops at the trigger
                if (!st_reg.ctrl.beginMode) begin
                    st_next.ctrl.arm = 1'b0;
                end
            end
            if (storeWord) begin
                // wrap sets full, counting carries on
                st_next.count = countInc;
                if (wrap) begin
                    st_next.full = 1'b1;
                    // begin-trigger storing ends at the fill
                    if (st_reg.ctrl.beginMode) begin
                        st_next.ctrl.arm = 1'b0;
                    end
                end
            end
        end

        // break pulse at the first fill
        st_next.brk = breakEvent;

        // Read data, one cycle after the strobe; a read of status clears it
        st_next.rdata = 8'h00;
        if (req.rd) begin
            unique case (req.addr)
                trace_pkg::CTRL_OFFSET: begin
                    st_next.rdata[trace_pkg::ARM_BIT]   = st_reg.ctrl.arm;
                    st_next.rdata[trace_pkg::BEGIN_BIT] = st_reg.ctrl.beginMode;
                    st_next.rdata[trace_pkg::BRK_BIT]   = st_reg.ctrl.breakEnable;
                end
                trace_pkg::COUNT_OFFSET:  st_next.rdata = countView;
                trace_pkg::CCX_OFFSET:    st_next.rdata = st_reg.ccx;
                trace_pkg::STATUS_OFFSET: begin
                    st_next.rdata  = {6'h00, st_reg.status};
                    st_next.status = 2'h0;
                end
                trace_pkg::MASK_OFFSET:   st_next.rdata = {6'h00, st_reg.mask};
                default:                  st_next.rdata = 8'h00;
            endcase
        end
        // A new event wins over the read that clears it
        st_next.status = st_next.status | events;

        st_next.capEn = st_next.ctrl.arm && (!st_next.ctrl.beginMode || st_next.trigSeen);
        // full means the whole buffer is valid
        // nonzero count while full means overwritten oldest data
        st_next.valid = st_next.full ? trace_pkg::BUFFER_WORDS : {1'b0, st_next.count};
        // extension compare runs in either operating mode
        st_next.extMatch = ((st_reg.ccx[trace_pkg::EXT_MSB:0] ^ core.highAddr) & cmpMask) == 6'h00;
        st_next.irq      = |(st_next.status & st_next.mask);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_reg <= STATE_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign regRdata      = st_reg.rdata;
    assign captureEnable = st_reg.capEn;
    assign validWords    = st_reg.valid;
    assign breakRequest  = st_reg.brk;
    assign extendedMatch = st_reg.extMatch;
    assign irq           = st_reg.irq;

    ////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_wrap;
        storeWord && st_reg.count == 6'h3f && !armWrite;
    endsequence

    sequence s_full_zero;
        st_reg.full && st_reg.count == 6'h00;
    endsequence

    // Separate tally, so the full flag is not only checked against its own counter
    logic [6:0] storedSinceArm;

    always_ff @(posedge clk) begin
        if (rst || armWrite) begin
            storedSinceArm <= 7'h00;
        end else if (storeWord && storedSinceArm != trace_pkg::BUFFER_WORDS) begin
            storedSinceArm <= storedSinceArm + 7'h01;
        end
    end

    sequence s_end_trigger;
        st_reg.ctrl.arm && !st_reg.ctrl.beginMode && core.trigger && !armWrite;
    endsequence

    sequence s_begin_trigger;
        st_reg.ctrl.arm && st_reg.ctrl.beginMode && core.trigger && !req.wr && !wrap;
    endsequence

    a_full_on_wrap: assert property (s_wrap |=> st_reg.full)
        else $error("full flag not set after wrap");

    a_full_all_valid: assert property (st_reg.full |-> validWords == 7'h40)
        else $error("full buffer not reported as 64 words");

    a_arm_clears_full: assert property (armWrite |=> !st_reg.full && st_reg.count == 6'h00)
        else $error("arming did not clear count register");

    a_count_readback: assert property (
        req.rd && req.addr == 8'h24 |=> regRdata == $past(countView))
        else $error("count readback wrong");

    a_end_keeps_count: assert property (
        s_wrap ##0 !st_reg.ctrl.beginMode ##1 storeWord && !armWrite |=> st_reg.count == 6'h01)
        else $error("end-trigger counting stopped after wrap");

    a_arm_clears_reg: assert property (armWrite |=> countView == 8'h00)
        else $error("count register not cleared on arming");

    a_begin_disarm: assert property (
        s_wrap ##0 st_reg.ctrl.beginMode |=> s_full_zero ##0 !st_reg.ctrl.arm)
        else $error("begin-trigger storing not ended at fill");

    a_break_pulse: assert property (
        breakRequest |-> $past(fullEvent) && $past(st_reg.ctrl.breakEnable) ##1 !breakRequest)
        else $error("break request without enabled first fill");

    a_count_step: assert property (
        storeWord && !armWrite |=> st_reg.count == $past(countInc))
        else $error("count did not advance by one");

    a_page_none: assert property (pageType == trace_pkg::PAGE_NONE |=> extendedMatch)
        else $error("normal paging must not compare");

    a_upper_sel_ignored: assert property (
        st_reg.ccx[trace_pkg::SEL_MSB:trace_pkg::SEL_LSB] == 2'h2 |=> extendedMatch)
        else $error("select 10 did not act as no compare");

    a_irq_level: assert property (
        (st_reg.status & st_reg.mask) != 2'h0 |-> irq || $past(events) != 2'h0)
        else $error("interrupt not raised for unmasked status");

    a_full_by_tally: assert property (
        st_reg.full == (storedSinceArm == trace_pkg::BUFFER_WORDS))
        else $error("full flag disagrees with words stored since arming");

    a_full_sticky: assert property (
        st_reg.full && !armWrite |=> st_reg.full)
        else $error("full flag dropped without arming");

    a_status_on_fill: assert property (
        fullEvent |=> st_reg.status[trace_pkg::EV_FULL])
        else $error("fill event not recorded in status");

    a_count_by_tally: assert property (
        !st_reg.full |-> st_reg.count == storedSinceArm[5:0])
        else $error("count differs from words stored");

    a_count_read_only: assert property (
        req.wr && req.addr == trace_pkg::COUNT_OFFSET && !storeWord |=> $stable(countView))
        else $error("write changed the count register");

    a_rdata_idle: assert property (
        !req.rd |=> regRdata == 8'h00)
        else $error("read data outside the answer cycle");

    a_count_wraps: assert property (
        s_wrap |=> st_reg.count == 6'h00)
        else $error("count did not wrap to zero");

    a_end_wrap_stores: assert property (
        s_wrap ##0 !st_reg.ctrl.beginMode && !core.trigger && !req.wr |=> captureEnable)
        else $error("end-trigger storing stopped at wrap");

    a_begin_fill_stop: assert property (
        s_wrap ##0 st_reg.ctrl.beginMode |=> !captureEnable)
        else $error("capture still enabled after begin-trigger fill");

    a_break_status: assert property (
        breakEvent |=> breakRequest && st_reg.status[trace_pkg::EV_BREAK])
        else $error("break event not signalled");

    a_break_disabled: assert property (
        !st_reg.ctrl.breakEnable |=> !breakRequest)
        else $error("break request while break enable clear");

    a_wrap_new_data: assert property (
        st_reg.full && storeWord && !armWrite |=> st_reg.full && validWords == 7'h40)
        else $error("overwrite lost the full buffer");

    a_program_compare: assert property (
        st_reg.ccx[trace_pkg::SEL_LSB] |=>
            extendedMatch == ($past(st_reg.ccx[trace_pkg::EXT_MSB:0]) == $past(core.highAddr)))
        else $error("program page compare wrong");

    a_end_trig_stop: assert property (
        s_end_trigger |=> !captureEnable)
        else $error("end-trigger storing continued after trigger");

    a_begin_trig_start: assert property (
        s_begin_trigger |=> captureEnable)
        else $error("begin-trigger storing did not start");

    a_arm_begin_waits: assert property (
        armWrite && req.wdata[trace_pkg::BEGIN_BIT] |=> !captureEnable)
        else $error("begin-trigger storing started before trigger");

    a_idle_count: assert property (
        !storeWord && !armWrite |=> $stable(st_reg.count))
        else $error("count moved without a stored word");

endmodule

// [verification/core_model.sv]
// Core-side partner: word strobes, trigger pulses, expanded address bits.
// Assumes the bench calls its tasks from one process after reset.
`timescale 1ns/100ps

module core_model (
    // Clock
    input  wire logic       clk,
    // Core signals
    output logic            wordStrobe,
    output logic            trigger,
    output logic      [5:0] expandedAddressBus
);
    initial begin
        wordStrobe = 1'b0;
        trigger = 1'b0;
        expandedAddressBus = 6'h00;
    end

    ////////////////////////////////////////////////////////////////////////
    // Slow mode leaves an idle cycle after every stored word
    task automatic burst(input int n, input bit slow);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            wordStrobe <= 1'b1;
            if (slow) begin
                @(posedge clk);
                wordStrobe <= 1'b0;
            end
        end
        @(posedge clk);
        wordStrobe <= 1'b0;
    endtask

    task automatic pulseTrig;
        @(posedge clk);
        trigger <= 1'b1;
        @(posedge clk);
        trigger <= 1'b0;
    endtask

    task automatic setPage(input logic [5:0] v);
        @(posedge clk);
        expandedAddressBus <= v;
    endtask
endmodule

// [verification/trace_count_and_page_compare_tb.sv]
// Self-checking bench for the trace counter and page compare.
// Assumes a 10 MHz clock and the core model as far side.
`timescale 1ns/100ps

module trace_count_and_page_compare_tb;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWdata = 8'h00;
    logic       regWr = 1'b0;
    logic       regRd = 1'b0;
    logic [7:0] regRdata;
    logic       wordStrobe;
    logic       trigger;
    logic [5:0] expandedAddressBus;
    logic       captureEnable;
    logic [6:0] validWords;
    logic       breakRequest;
    logic       extendedMatch;
    logic       irq;
    int         fail_count = 0;
    int         tests_run = 0;
    int         seed = 36;
    int         mCnt;
    bit         mFull, mArm, mBeg, mBrkEn, mTrig, mPulse, watch;
    logic [7:0] v;
    logic [1:0] sel;
    logic [5:0] ext, adr;

    always #50 clk = ~clk;

    trace_count_and_page_compare u_dut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .wordStrobe(wordStrobe), .trigger(trigger),
        .expandedAddressBus(expandedAddressBus), .captureEnable(captureEnable), .validWords(validWords),
        .breakRequest(breakRequest), .extendedMatch(extendedMatch), .irq(irq));

    core_model u_core (.clk(clk), .wordStrobe(wordStrobe), .trigger(trigger),
        .expandedAddressBus(expandedAddressBus));

    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chkReg(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %0t: register got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chkOut(input logic [6:0] got, input logic [6:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %0t: output got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        @(negedge clk);
        d = regRdata;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Reference model; an arm write wins over a strobe in the same cycle
    always @(posedge clk) begin
        mPulse = 0;
        if (rst) begin
            {mCnt, mFull, mArm, mBeg, mBrkEn, mTrig} = 0;
        end else if (regWr && regAddr == trace_pkg::CTRL_OFFSET) begin
            mArm = regWdata[trace_pkg::ARM_BIT];
            mBeg = regWdata[trace_pkg::BEGIN_BIT];
            mBrkEn = regWdata[trace_pkg::BRK_BIT];
            if (mArm)
                {mCnt, mFull, mTrig} = 0;
        end else begin
            // A word stored in the end-trigger cycle still counts
            if (mArm && (!mBeg || mTrig) && wordStrobe) begin
                mCnt = (mCnt + 1) % 64;
                if (mCnt == 0) begin
                    mPulse = !mFull && mBrkEn;
                    mFull = 1;
                    if (mBeg)
                        mArm = 0;
                end
            end
            if (mArm && trigger) begin
                if (mBeg)
                    mTrig = 1;
                else
                    mArm = 0;
            end
        end
    end

    always @(negedge clk) begin
        if (watch) begin
            chkOut(validWords, mFull ? 7'h40 : 7'(mCnt));
            chkOut({6'h00, breakRequest}, {6'h00, mPulse});
        end
    end

    // Span is about fifty times the expected run length
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        $display("Error %0t: timeout", $time);
        tally_and_finish();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chkOut({validWords[5:0], irq}, 7'h00);
        watch = 1;
        wr(trace_pkg::MASK_OFFSET, 8'h03);
        wr(trace_pkg::CTRL_OFFSET, 8'h88);
        u_core.burst(64, 1'b0);
        u_core.burst(3, 1'b1);
        rd(trace_pkg::COUNT_OFFSET, v);
        chkReg(v, 8'h83);
        chkOut({6'h00, irq}, 7'h01);
        rd(trace_pkg::STATUS_OFFSET, v);
        chkReg(v, 8'h03);
        repeat (2) @(negedge clk);
        chkOut({6'h00, irq}, 7'h00);
        u_core.pulseTrig();
        u_core.burst(2, 1'b0);
        chkOut({6'h00, captureEnable}, 7'h00);
        wr(trace_pkg::COUNT_OFFSET, 8'hff);
        wr(trace_pkg::CTRL_OFFSET, 8'h80);
        rd(trace_pkg::COUNT_OFFSET, v);
        chkReg(v, 8'h00);
        rd(8'h30, v);
        chkReg(v, 8'h00);
        $display("Test end-trigger fill done");
        wr(trace_pkg::MASK_OFFSET, 8'h00);
        wr(trace_pkg::CTRL_OFFSET, 8'h90);
        u_core.burst(5, 1'b1);
        chkOut({6'h00, captureEnable}, 7'h00);
        u_core.pulseTrig();
        repeat (2) @(negedge clk);
        chkOut({6'h00, captureEnable}, 7'h01);
        u_core.burst(66, 1'b0);
        rd(trace_pkg::COUNT_OFFSET, v);
        chkReg(v, 8'h80);
        chkOut({5'h00, captureEnable, irq}, 7'h00);
        wr(trace_pkg::MASK_OFFSET, 8'h01);
        repeat (2) @(negedge clk);
        chkOut({6'h00, irq}, 7'h01);
        rd(trace_pkg::STATUS_OFFSET, v);
        chkReg(v, 8'h01);
        $display("Test begin-trigger fill done");
        for (int i = 0; i < 24; i++) begin
            sel = i[1:0];
            // Top two compare bits kept at zero
            ext = 6'($random(seed)) & 6'h0f;
            adr = (i % 3 == 0) ? ext : 6'($random(seed));
            wr(trace_pkg::CCX_OFFSET, {sel, ext});
            u_core.setPage(adr);
            repeat (2) @(posedge clk);
            @(negedge clk);
            chkOut({6'h00, extendedMatch}, {6'h00, !sel[0] || ext == adr});
            rd(trace_pkg::CCX_OFFSET, v);
            chkReg(v, {sel, ext});
        end
        $display("Test page compare done");
        tally_and_finish();
    end
endmodule
